// ==== design/cfd_pkg.sv ====
/*
 * constants, types and decode functions shared by the fetch/decode/timing core.
 * assumes a single system clock; program memory answers within one machine cycle.
 */
`default_nettype none

package cfd_pkg;

  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned MCYC_CLOCKS   = 4;
  localparam logic [1:0]  PH_FETCH      = 2'h0;
  localparam logic [1:0]  PH_LAST       = 2'(MCYC_CLOCKS - 1);
  localparam logic [15:0] PC_RESET      = 16'h0000;

  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic [7:0] OP_ADD_IMM   = 8'h24;
  localparam logic [7:0] OP_ADD_DIR   = 8'h25;
  localparam logic [7:0] OP_ADD_IND   = 8'h26;
  localparam logic [7:0] OP_ADD_REG   = 8'h28;
  localparam logic [7:0] OP_ADDC_IMM  = 8'h34;
  localparam logic [7:0] OP_ADDC_DIR  = 8'h35;
  localparam logic [7:0] OP_ADDC_IND  = 8'h36;
  localparam logic [7:0] OP_ADDC_REG  = 8'h38;
  localparam logic [7:0] OP_LJMP      = 8'h02;
  localparam logic [7:0] OP_LCALL     = 8'h12;
  localparam logic [7:0] OP_JMP_IND   = 8'h73;
  localparam logic [7:0] OP_SJMP      = 8'h80;
  localparam logic [3:0] LO_ABS_JMP   = 4'h1;

  typedef enum logic [2:0] {
    CFD_SRC_NONE = 3'h0,
    CFD_SRC_REG  = 3'h1,
    CFD_SRC_IND  = 3'h2,
    CFD_SRC_DIR  = 3'h3,
    CFD_SRC_IMM  = 3'h4
  } cfd_src_t;

  typedef enum logic [2:0] {
    CFD_ST_OPC  = 3'b001,
    CFD_ST_OPND = 3'b010,
    CFD_ST_CALC = 3'b100
  } cfd_state_t;

  // byte count of any opcode of the instruction set
  function automatic logic [1:0] cfd_len(input logic [7:0] op);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = op[7:4];
    lo = op[3:0];
    cfd_len = 2'd1;
    if (op == 8'h02 || op == 8'h12 || op == 8'h10 || op == 8'h20 || op == 8'h30 ||
        op == 8'h43 || op == 8'h53 || op == 8'h63 || op == 8'h75 || op == 8'h85 ||
        op == 8'h90 || op == 8'hd5 || (hi == 4'hb && lo >= 4'h4)) begin
      cfd_len = 2'd3;
    end else if (lo == 4'h1 || (lo == 4'h0 && hi >= 4'h4 && hi <= 4'hd && hi != 4'h9) ||
                 (lo == 4'h2 && hi >= 4'h4 && hi <= 4'hd) ||
                 (lo == 4'h4 && (hi >= 4'h2 && hi <= 4'h9) && hi != 4'h8) ||
                 (lo == 4'h5 && hi != 4'ha) ||
                 ((lo == 4'h6 || lo == 4'h7) && (hi == 4'h7 || hi == 4'h8 || hi == 4'ha)) ||
                 (lo >= 4'h8 && (hi == 4'h7 || hi == 4'h8 || hi == 4'ha || hi == 4'hd))) begin
      cfd_len = 2'd2;
    end
  endfunction

  function automatic logic cfd_is_jump(input logic [7:0] op);
    cfd_is_jump = (op[3:0] == LO_ABS_JMP) || op == OP_LJMP || op == OP_LCALL ||
                  op == OP_JMP_IND || op == OP_SJMP;
  endfunction

  function automatic logic cfd_is_add(input logic [7:0] op);
    cfd_is_add = (op[7:4] == 4'h2 || op[7:4] == 4'h3) && op[3:0] >= 4'h4;
  endfunction

  function automatic cfd_src_t cfd_src(input logic [7:0] op);
    cfd_src = CFD_SRC_NONE;
    if (cfd_is_add(op)) begin
      if (op[3]) begin
        cfd_src = CFD_SRC_REG;
      end else if (op[2:1] == 2'b11) begin
        cfd_src = CFD_SRC_IND;
      end else if (op[0]) begin
        cfd_src = CFD_SRC_DIR;
      end else begin
        cfd_src = CFD_SRC_IMM;
      end
    end
  endfunction

endpackage

`default_nettype wire

// ==== design/cfd_adder.sv ====
/*
 * registered accumulator adder with carry, half-carry and overflow flags.
 * assumes operands are stable on the cycle that start is high.
 */
`timescale 1ns/1ps
`default_nettype none

module cfd_adder (
  input  wire logic       clk,       // system clock
  input  wire logic       rst_n,     // synchronised reset
  input  wire logic       start,     // one-cycle launch
  input  wire logic       use_cy,    // add carry-in too
  input  wire logic [7:0] acc,       // accumulator value
  input  wire logic [7:0] opnd,      // second operand
  input  wire logic       cy_in,     // carry flag in
  output logic      [7:0] sum_reg,   // result
  output logic            cy_reg,    // carry out of bit 7
  output logic            ac_reg,    // carry out of bit 3
  output logic            ov_reg,    // signed overflow
  output logic            done_reg   // result valid pulse
);

  logic       cin;
  logic [4:0] lo_sum;
  logic [3:0] mid_sum;
  logic [1:0] top_sum;

  always_comb begin
    cin     = use_cy & cy_in;
    lo_sum  = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    mid_sum = {1'b0, acc[6:4]} + {1'b0, opnd[6:4]} + {3'h0, lo_sum[4]};
    top_sum = {1'b0, acc[7]} + {1'b0, opnd[7]} + {1'b0, mid_sum[3]};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_reg  <= 8'h00;
      cy_reg   <= 1'b0;
      ac_reg   <= 1'b0;
      ov_reg   <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= start;
      if (start) begin
        // same flag semantics as the classic core: ov is carry6 xor carry7
        sum_reg <= {top_sum[0], mid_sum[2:0], lo_sum[3:0]};
        cy_reg  <= top_sum[1];
        ac_reg  <= lo_sum[4];
        ov_reg  <= top_sum[1] ^ mid_sum[3];
      end
    end
  end

endmodule

`default_nettype wire

// ==== design/cfd_core.sv ====
/*
 * instruction fetch, decode and machine-cycle timing for the 8-bit core.
 * assumes program memory returns the byte for PM_ADDR by the last clock
 * of the machine cycle in which PM_RD pulsed, and that the datapath
 * presents OPERAND_IN by that same clock, and the branch answer by the last clock of the address cycle.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - every opcode is fetched, sized and handed to the datapath unchanged.
// - a machine cycle is exactly four system clocks; timing counts these.
// - at most one program byte fetched per machine cycle; cycles equal bytes except for unconditional jumps and calls.
// - unconditional jumps and calls add one machine cycle to compute the new address.
// - 28-2F add Rn, 26/27 add @Ri; one byte, one machine cycle.
// - 25 adds direct, 24 adds immediate; two bytes, two machine cycles.
// - 38-3F add Rn plus carry, 36 adds @R0 plus carry; one cycle.
// - 37 adds @R1 plus carry; 35/34 direct/immediate plus carry, two cycles.
module cfd_core
  import cfd_pkg::*;
(
  input  wire logic             CLK_SYS,     // 125 MHz system clock
  input  wire logic             RST_B,       // async reset, active low
  output logic           [15:0] PM_ADDR,     // program byte address
  output logic                  PM_RD,       // program read strobe
  input  wire logic      [7:0]  PM_DATA,     // program byte
  output logic           [7:0]  OPCODE,      // issued opcode
  output logic           [7:0]  OPND1,       // first operand byte
  output logic           [7:0]  OPND2,       // second operand byte
  output logic                  INSN_VALID,  // instruction issue pulse
  output cfd_pkg::cfd_src_t     SRC_KIND,    // add operand source
  output logic           [7:0]  SRC_ADDR,    // register, Ri or direct address
  input  wire logic      [7:0]  OPERAND_IN,  // fetched add operand
  input  wire logic      [7:0]  ACC_IN,      // accumulator
  input  wire logic             CY_IN,       // carry flag
  output logic           [7:0]  ACC_OUT,     // add result
  output logic                  CY_OUT,      // new carry
  output logic                  AC_OUT,      // new auxiliary carry
  output logic                  OV_OUT,      // new overflow
  output logic                  ACC_WE,      // result write pulse
  input  wire logic             BR_TAKE,     // load branch target
  input  wire logic      [15:0] BR_TARGET,   // branch target
  output logic           [1:0]  MCYC_PHASE   // clock within machine cycle
);

  logic        rst_s1_n;
  logic        rst_n;
  logic [1:0]  phase_reg;
  cfd_state_t  state_reg;
  logic [15:0] pc_reg;
  logic [7:0]  op_reg;
  logic [7:0]  b1_reg;
  logic [1:0]  len_reg;
  logic [1:0]  idx_reg;
  logic        issue;
  logic [1:0]  opc_len;
  logic        last_byte;
  logic        add_start;

  ////////////////////////////////////////////////////////////////////////
  // reset release

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_n <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_n <= 1'b1;
      rst_n    <= rst_s1_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // machine cycle phase

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= PH_FETCH;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign MCYC_PHASE = phase_reg;

  ////////////////////////////////////////////////////////////////////////
  // fetch and sequencing

  assign opc_len   = cfd_len(PM_DATA);
  // final byte of the instruction lands this clock
  assign last_byte = (state_reg == CFD_ST_OPC) ? (opc_len == 2'd1)
                                               : (idx_reg + 2'd1 == len_reg);
  // issue on the capture clock of the final byte
  assign issue     = (phase_reg == PH_LAST) && (state_reg != CFD_ST_CALC) && last_byte;
  // only one read per machine cycle, never in the address cycle
  assign PM_RD     = (phase_reg == PH_FETCH) && (state_reg != CFD_ST_CALC);
  assign PM_ADDR   = pc_reg;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CFD_ST_OPC;
      pc_reg    <= PC_RESET;
      op_reg    <= OP_NOP;
      b1_reg    <= 8'h00;
      len_reg   <= 2'd1;
      idx_reg   <= 2'd0;
    end else if (phase_reg == PH_LAST) begin
      case (state_reg)
        CFD_ST_OPC: begin
          pc_reg  <= pc_reg + 16'h0001;
          op_reg  <= PM_DATA;
          len_reg <= opc_len;
          idx_reg <= 2'd1;
          if (opc_len == 2'd1) begin
            // nop and single-byte adds finish here
            state_reg <= cfd_is_jump(PM_DATA) ? CFD_ST_CALC : CFD_ST_OPC;
          end else begin
            state_reg <= CFD_ST_OPND;
          end
        end
        CFD_ST_OPND: begin
          pc_reg  <= pc_reg + 16'h0001;
          idx_reg <= idx_reg + 2'd1;
          if (idx_reg == 2'd1) begin
            b1_reg <= PM_DATA;
          end
          if (last_byte) begin
            state_reg <= cfd_is_jump(op_reg) ? CFD_ST_CALC : CFD_ST_OPC;
          end
        end
        CFD_ST_CALC: begin
          // extra cycle: the datapath resolves the target meanwhile
          if (BR_TAKE) begin
            pc_reg <= BR_TARGET;
          end
          state_reg <= CFD_ST_OPC;
        end
        default: begin
          state_reg <= CFD_ST_OPC;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operand source for the datapath

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      SRC_KIND <= CFD_SRC_NONE;
      SRC_ADDR <= 8'h00;
    end else if (phase_reg == PH_LAST && state_reg == CFD_ST_OPC) begin
      SRC_KIND <= cfd_src(PM_DATA);
      SRC_ADDR <= {5'h00, PM_DATA[3] ? PM_DATA[2:0] : {2'b00, PM_DATA[0]}};
    end else if (phase_reg == PH_LAST && state_reg == CFD_ST_OPND && idx_reg == 2'd1) begin
      // direct address arrives as the second byte
      SRC_ADDR <= PM_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // issue to the datapath

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      OPCODE     <= OP_NOP;
      OPND1      <= 8'h00;
      OPND2      <= 8'h00;
      INSN_VALID <= 1'b0;
    end else begin
      INSN_VALID <= issue;
      if (issue) begin
        if (state_reg == CFD_ST_OPC) begin
          OPCODE <= PM_DATA;
          OPND1  <= 8'h00;
          OPND2  <= 8'h00;
        end else begin
          OPCODE <= op_reg;
          OPND1  <= (idx_reg == 2'd1) ? PM_DATA : b1_reg;
          OPND2  <= (idx_reg == 2'd2) ? PM_DATA : 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // add and add-with-carry

  logic       add_op;
  logic [7:0] add_opnd;

  always_comb begin
    add_op   = (state_reg == CFD_ST_OPC) ? cfd_is_add(PM_DATA) : cfd_is_add(op_reg);
    // immediate comes straight off the program bus, others from the datapath
    add_opnd = (state_reg == CFD_ST_OPND && SRC_KIND == CFD_SRC_IMM) ? PM_DATA : OPERAND_IN;
  end

  assign add_start = issue && add_op;

  cfd_adder u_adder (
    .clk      (CLK_SYS),
    .rst_n    (rst_n),
    .start    (add_start),
    .use_cy   ((state_reg == CFD_ST_OPC) ? PM_DATA[4] : op_reg[4]),
    .acc      (ACC_IN),
    .opnd     (add_opnd),
    .cy_in    (CY_IN),
    .sum_reg  (ACC_OUT),
    .cy_reg   (CY_OUT),
    .ac_reg   (AC_OUT),
    .ov_reg   (OV_OUT),
    .done_reg (ACC_WE)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  logic [7:0] gap_cnt;
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= 8'h00;
    end else begin
      gap_cnt <= INSN_VALID ? 8'h01 : gap_cnt + 8'h01;
    end
  end

  sequence nop_issue_s;
    INSN_VALID && OPCODE == OP_NOP;
  endsequence

  sequence single_add_s;
    INSN_VALID && (OPCODE[7:4] == 4'h2 || OPCODE[7:4] == 4'h3) && OPCODE[3:0] >= 4'h6;
  endsequence

  sequence double_add_s;
    INSN_VALID && (OPCODE == OP_ADD_IMM || OPCODE == OP_ADD_DIR);
  endsequence

  sequence carry_add2_s;
    INSN_VALID && (OPCODE == OP_ADDC_IMM || OPCODE == OP_ADDC_DIR);
  endsequence

  mcyc_phase_a: assert property (phase_reg == PH_LAST |=> phase_reg == PH_FETCH)
    else $error("machine cycle not four clocks");
  one_fetch_a: assert property (PM_RD |=> !PM_RD [*3])
    else $error("more than one fetch in a machine cycle");
  issue_align_a: assert property (INSN_VALID |-> phase_reg == PH_FETCH)
    else $error("issue off machine cycle boundary");
  jump_extra_a: assert property (INSN_VALID && cfd_is_jump(OPCODE) |-> !PM_RD [*4] ##1 PM_RD)
    else $error("jump lacks its address cycle");
  nop_next_a: assert property (nop_issue_s |=> !INSN_VALID [*3])
    else $error("issue inside the nop machine cycle");
  nop_time_a: assert property (nop_issue_s |-> ##[4:12] INSN_VALID)
    else $error("nop not followed by next issue");
  // opcode fetched one machine cycle before issue and issued from the opcode cycle
  add1_gap_a: assert property (single_add_s |-> $past(PM_RD, 4) && $past(state_reg) == CFD_ST_OPC)
    else $error("one-byte add not one machine cycle");
  add2_gap_a: assert property (double_add_s |-> gap_cnt >= 8'd8)
    else $error("two-byte add shorter than eight clocks");
  addc2_gap_a: assert property (carry_add2_s |-> $past(PM_RD, 4) && $past(PM_RD, 8))
    else $error("two-byte add with carry not two fetches");
  add_result_a: assert property (ACC_WE == (INSN_VALID && cfd_is_add(OPCODE)))
    else $error("add result not written");

endmodule

`default_nettype wire

// ==== dv/cfd_pmem.sv ====
/*
 * program memory model for the fetch/decode core.
 * assumes reads come one per machine cycle; the bench fills mem directly.
 */
`timescale 1ns/1ps
`default_nettype none

module cfd_pmem (
  input  wire logic        clk,   // system clock
  input  wire logic        rd,    // read strobe
  input  wire logic [15:0] addr,  // byte address
  input  wire logic        slow,  // answer after two clocks
  output logic      [7:0]  data   // program byte
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_reg;
  logic [2:0]  cnt_reg;
  logic [2:0]  lat_reg;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hff;
    end
    data = 8'h5a;
    addr_reg = 16'h0000;
    cnt_reg = 3'h0;
    lat_reg = 3'h1;
  end

  // latency is frozen at the strobe so a mid-read change cannot lose a byte
  always @(posedge clk) begin
    if (rd) begin
      addr_reg <= addr;
      lat_reg <= slow ? 3'h2 : 3'h1;
    end
    cnt_reg <= rd ? 3'h1 : (cnt_reg == 3'h0 || cnt_reg == 3'h4) ? 3'h0 : cnt_reg + 3'h1;
    // hold ends after the sampling edge, so junk replaces the byte
    if (cnt_reg == lat_reg) begin
      data <= mem[addr_reg];
    end else if (rd || cnt_reg == 3'h4) begin
      data <= ~data;
    end
  end
endmodule

`default_nettype wire

// ==== dv/tb.sv ====
/*
 * self-checking bench for cfd_core: runs instructions and checks spacing and results.
 * assumes cfd_pmem answers fetches; the bench plays the datapath.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import cfd_pkg::*;
  logic        CLK_SYS, RST_B, PM_RD, INSN_VALID, CY_IN, CY_OUT, AC_OUT, OV_OUT;
  logic        ACC_WE, BR_TAKE, lat_sel, take_br;
  logic [15:0] PM_ADDR, BR_TARGET, pc, pend_tgt;
  logic [7:0]  PM_DATA, OPCODE, OPND1, OPND2, SRC_ADDR, OPERAND_IN, ACC_IN, ACC_OUT;
  logic [1:0]  MCYC_PHASE;
  cfd_src_t    SRC_KIND;
  int          err_count, checks, first, pend_jmp;
  logic [7:0]  jl [3] = '{OP_LJMP, OP_SJMP, OP_LCALL};

  cfd_core cfd_core_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .PM_ADDR(PM_ADDR), .PM_RD(PM_RD),
    .PM_DATA(PM_DATA), .OPCODE(OPCODE), .OPND1(OPND1), .OPND2(OPND2),
    .INSN_VALID(INSN_VALID), .SRC_KIND(SRC_KIND), .SRC_ADDR(SRC_ADDR),
    .OPERAND_IN(OPERAND_IN), .ACC_IN(ACC_IN), .CY_IN(CY_IN), .ACC_OUT(ACC_OUT),
    .CY_OUT(CY_OUT), .AC_OUT(AC_OUT), .OV_OUT(OV_OUT), .ACC_WE(ACC_WE), .BR_TAKE(BR_TAKE),
    .BR_TARGET(BR_TARGET), .MCYC_PHASE(MCYC_PHASE));
  cfd_pmem cfd_pmem_inst (.clk(CLK_SYS), .rd(PM_RD), .addr(PM_ADDR), .slow(lat_sel),
    .data(PM_DATA));

  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic int exp_len(input logic [7:0] op);
    case (op)
      8'h02, 8'h12: return 3;
      8'h24, 8'h25, 8'h34, 8'h35, 8'h80: return 2;
      default: return 1;
    endcase
  endfunction

  // places one instruction at pc, plays the datapath, checks its issue
  task automatic issue(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                       input logic [15:0] tgt);
    int       len, jmp, add, n, rd, acc, opv, cyv, c, s;
    cfd_src_t kind;
    len = exp_len(op);
    jmp = (op == 8'h02 || op == 8'h12 || op == 8'h80);
    add = (op[7:5] == 3'b001) && (op[3:0] >= 4'h4);
    acc = $urandom_range(255);
    opv = (op[3:0] == 4'h4) ? int'(b1) : $urandom_range(255);
    cyv = $urandom_range(1);
    c = op[4] ? cyv : 0;
    cfd_pmem_inst.mem[pc] = op;
    cfd_pmem_inst.mem[pc + 16'h1] = b1;
    cfd_pmem_inst.mem[pc + 16'h2] = b2;
    @(posedge CLK_SYS);
    ACC_IN <= acc[7:0];
    OPERAND_IN <= opv[7:0];
    CY_IN <= cyv[0];
    lat_sel <= 1'($urandom_range(1));
    BR_TAKE <= pend_jmp[0] & take_br;
    BR_TARGET <= pend_tgt;
    n = 0;
    rd = 0;
    do begin
      @(negedge CLK_SYS);
      n++;
      if (INSN_VALID !== 1'b1) rd += (PM_RD === 1'b1);
    end while (INSN_VALID !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_count++;
      $display("FAIL issue expected pulse seen none");
      complete_run();
    end
    if (first == 0) begin
      cmp("gap", 16'(4 * len + 4 * pend_jmp), 16'(n));
      cmp("reads", 16'(len - 1 + pend_jmp), 16'(rd));
    end
    kind = !add ? CFD_SRC_NONE : op[3] ? CFD_SRC_REG : (op[2:1] == 2'b11) ? CFD_SRC_IND :
           op[0] ? CFD_SRC_DIR : CFD_SRC_IMM;
    cmp("opcode", {8'h00, op}, {8'h00, OPCODE});
    cmp("pm_addr", pc + 16'(len), PM_ADDR);
    cmp("phase", 16'h0000, {14'h0000, MCYC_PHASE});
    cmp("opnd1", {8'h00, len > 1 ? b1 : 8'h00}, {8'h00, OPND1});
    cmp("opnd2", {8'h00, len > 2 ? b2 : 8'h00}, {8'h00, OPND2});
    cmp("src_kind", 16'(kind), 16'(SRC_KIND));
    cmp("acc_we", 16'(add), {15'h0000, ACC_WE});
    if (add != 0) begin
      s = acc + opv + c;
      cmp("acc_out", 16'(s & 255), {8'h00, ACC_OUT});
      cmp("flags", 16'({s > 255, ((acc & 15) + (opv & 15) + c) > 15,
          ((acc ^ s) & (opv ^ s) & 128) != 0}), {13'h0000, CY_OUT, AC_OUT, OV_OUT});
      if (kind != CFD_SRC_IMM) begin
        cmp("src_addr", {8'h00, op[3] ? {5'h00, op[2:0]} : (kind == CFD_SRC_IND) ?
            {7'h00, op[0]} : b1}, {8'h00, SRC_ADDR});
      end
    end
    first = 0;
    // short jump left untaken so the fall-through path is exercised
    take_br = (op != OP_SJMP);
    pend_jmp = jmp;
    pend_tgt = tgt;
    pc = (jmp != 0 && take_br) ? tgt : pc + 16'(len);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    RST_B = 1'b0;
    OPERAND_IN = 8'h00;
    ACC_IN = 8'h00;
    CY_IN = 1'b0;
    BR_TAKE = 1'b0;
    BR_TARGET = 16'h0000;
    lat_sel = 1'b0;
    take_br = 1'b0;
    pc = PC_RESET;
    pend_tgt = 16'h0000;
    first = 1;
    pend_jmp = 0;
    err_count = 0;
    checks = 0;
    void'($urandom(32'hdaec));
    repeat (4) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      issue(OP_NOP, 8'h00, 8'h00, 16'h0000);
    end
    $display("test nop done");
    for (int o = 'h24; o <= 'h3f; o++) begin
      if (o < 'h30 || o > 'h33) issue(8'(o), 8'($urandom_range(255)), 8'h00, 16'h0000);
    end
    $display("test add done");
    for (int i = 0; i < 3; i++) begin
      issue(jl[i], 8'h20, 8'(i), 16'h2000 + 16'(i * 256));
      issue(OP_ADD_IMM, 8'($urandom_range(255)), 8'h00, 16'h0000);
    end
    $display("test jump done");
    complete_run();
  end
endmodule

`default_nettype wire
